// ### ieee_status_pkg.sv
// ieee_status_pkg: constants, command codes and the identification text of the
// status reporting block; assumes the bus front end decodes commands into codes.
package ieee_status_pkg;

    // gpib multiline bus command codes, seen with atn asserted
    localparam logic [7:0] BUS_CODE_DEVICE_CLEAR = 8'h14;
    localparam logic [7:0] BUS_CODE_SELECTED_CLEAR = 8'h04;

    // event flag bit positions (weights 128 down to 1)
    localparam int FLAG_POWER_ON = 7;
    localparam int FLAG_USER_REQUEST = 6;
    localparam int FLAG_COMMAND_ERROR = 5;
    localparam int FLAG_EXECUTION_ERROR = 4;
    localparam int FLAG_DEVICE_ERROR = 3;
    localparam int FLAG_QUERY_ERROR = 2;
    localparam int FLAG_TRIGGER = 1;
    localparam int FLAG_OP_COMPLETE = 0;

    // reset values
    localparam logic [7:0] EVENT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;

    // response buffer shape
    localparam int RESP_DEPTH = 24;
    localparam int RESP_IDX_W = 5;

    // ascii characters used in responses
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_NEWLINE = 8'h0a;

    // identification text, arbitrary maker and model values, newline appended
    localparam int IDN_LEN = 18;
    localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "ACME,PC100,0,1.0\n\n";
    localparam logic [RESP_IDX_W-1:0] IDN_SEND_LEN = 5'h11;

    // decoded common commands
    typedef enum logic [2:0]
    {
        ISR_CMD_CLEAR_STATUS = 3'b000,
        ISR_CMD_ENABLE_WRITE = 3'b001,
        ISR_CMD_ENABLE_QUERY = 3'b010,
        ISR_CMD_FLAGS_QUERY = 3'b011,
        ISR_CMD_IDENT_QUERY = 3'b100
    } isr_cmd_t;

endpackage

// ### isr_status_reporting.sv
// isr_status_reporting: standard event flags, enable mask, summary bit, bus clears
// and the response byte stream for the status queries.
// assumes a front end that decodes bus bytes and common commands into one-cycle strobes.
//
// Summary of operation
// R1: bus clear and interface clear commands are acted on only while atn is asserted.
// R2: device clear, or selected clear while addressed, flushes buffers, resets the parser and drops pending work.
// R3: interface clear halts bus activity, unaddresses the device, disables serial poll and hands control to the system controller.
// R4: clear status zeroes the event flags, clears the error queue and cancels the opc request.
// R5: clear status right after a message terminator also empties the output queue and clears message available.
// R6: the enable write loads an eight bit mask where a one enables the matching flag.
// R7: the enable query returns the mask as decimal text ended by newline.
// R8: the summary bit is set whenever a flag is set and enabled.
// R9: bit 7 records power on and bit 6 records a front panel key press.
// R10: bits 5 to 2 record command, execution, device dependent and query errors.
// R11: bit 1 is the trigger flag and bit 0 the operation complete flag.
// R12: the flags query returns the sum of set bit weights as decimal text.
// R13: answering the flags query clears every flag.
// R14: the identification query returns a fixed maker and model text with the revision.
// R15: the controller reads a response before the next message, else it is dropped and a query error logged.
// R16: a set flag stays set until read or cleared by clear status; the code also clears the flags on a flags query that gets no answer.
`timescale 1ns/1ns
module isr_status_reporting
    import ieee_status_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // gpib bus command side
    input wire logic atn,
    input wire logic busCmdValid,
    input wire logic [7:0] busCmdCode,
    input wire logic addressed,
    input wire logic ifc,
    // common command side
    input wire logic cmdValid,
    input wire ieee_status_pkg::isr_cmd_t cmdCode,
    input wire logic [7:0] cmdData,
    input wire logic afterTerminator,
    // instrument event strobes
    input wire logic keyPress,
    input wire logic commandError,
    input wire logic executionError,
    input wire logic deviceError,
    input wire logic triggerSeen,
    input wire logic opComplete,
    // response stream
    output logic txValid_q,
    output logic [7:0] txData_q,
    input wire logic txReady,
    // status outputs
    output logic [7:0] eventEnable_q,
    output logic [7:0] eventFlags_q,
    output logic summaryBit_q,
    output logic messageAvail_q,
    // clear and interface actions, one-cycle pulses except controllerIsSystem_q
    output logic deviceClear_q,
    output logic busHalt_q,
    output logic unaddress_q,
    output logic serialPollOff_q,
    output logic controllerIsSystem_q,
    output logic errorQueueClear_q,
    output logic opcRequestClear_q,
    output logic outputQueueClear_q
);
    import ieee_status_pkg::*;

    // decimal text of a byte, digits then newline, leading zeros dropped
    function automatic logic [31:0] dec_text(input logic [7:0] v);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] u;
        h = v / 8'd100;
        t = (v / 8'd10) % 8'd10;
        u = v % 8'd10;
        if (h != 8'h00)
            dec_text = {CHAR_ZERO + h, CHAR_ZERO + t, CHAR_ZERO + u, CHAR_NEWLINE};
        else if (t != 8'h00)
            dec_text = {CHAR_ZERO + t, CHAR_ZERO + u, CHAR_NEWLINE, 8'h00};
        else
            dec_text = {CHAR_ZERO + u, CHAR_NEWLINE, 8'h00, 8'h00};
    endfunction

    function automatic logic [RESP_IDX_W-1:0] dec_len(input logic [7:0] v);
        if (v >= 8'd100)
            dec_len = 5'h04;
        else if (v >= 8'd10)
            dec_len = 5'h03;
        else
            dec_len = 5'h02;
    endfunction

    logic [7:0] eventEnable_d;
    logic [7:0] eventFlags_d;
    logic summaryBit_d;
    logic powerOnPending_q;
    logic powerOnPending_d;
    logic deviceClear_d;
    logic busHalt_d;
    logic unaddress_d;
    logic serialPollOff_d;
    logic controllerIsSystem_d;
    logic errorQueueClear_d;
    logic opcRequestClear_d;
    logic outputQueueClear_d;
    logic [7:0] respBuf_q [RESP_DEPTH];
    logic [7:0] respBuf_d [RESP_DEPTH];
    logic [RESP_IDX_W-1:0] respLen_q;
    logic [RESP_IDX_W-1:0] respLen_d;
    logic [RESP_IDX_W-1:0] respIdx_q;
    logic [RESP_IDX_W-1:0] respIdx_d;
    logic txValid_d;
    logic [7:0] txData_d;

    // status and control state
    always_comb
    begin
        logic busCmd;
        logic clearFlags;
        logic [7:0] setFlags;
        busCmd = busCmdValid && atn; // [R1]
        clearFlags = 1'b0;
        setFlags = 8'h00;
        eventEnable_d = eventEnable_q;
        powerOnPending_d = 1'b0;
        deviceClear_d = busCmd && ((busCmdCode == BUS_CODE_DEVICE_CLEAR)
            || (busCmdCode == BUS_CODE_SELECTED_CLEAR && addressed)); // [R2]
        busHalt_d = ifc && atn; // [R3]
        unaddress_d = ifc && atn; // [R3]
        serialPollOff_d = ifc && atn; // [R3]
        controllerIsSystem_d = controllerIsSystem_q || (ifc && atn); // [R3]
        errorQueueClear_d = 1'b0;
        opcRequestClear_d = 1'b0;
        outputQueueClear_d = 1'b0;
        if (cmdValid)
        begin
            unique case (cmdCode)
                ISR_CMD_CLEAR_STATUS:
                begin
                    clearFlags = 1'b1; // [R4]
                    errorQueueClear_d = 1'b1; // [R4]
                    opcRequestClear_d = 1'b1; // [R4]
                    outputQueueClear_d = afterTerminator; // [R5]
                end
                ISR_CMD_ENABLE_WRITE: eventEnable_d = cmdData; // [R6]
                ISR_CMD_FLAGS_QUERY: clearFlags = 1'b1; // [R13]
                default:
                begin
                end
            endcase
        end
        setFlags[FLAG_POWER_ON] = powerOnPending_q; // [R9]
        setFlags[FLAG_USER_REQUEST] = keyPress; // [R9]
        setFlags[FLAG_COMMAND_ERROR] = commandError; // [R10]
        setFlags[FLAG_EXECUTION_ERROR] = executionError; // [R10]
        setFlags[FLAG_DEVICE_ERROR] = deviceError; // [R10]
        // a new command while a response is still unread loses it [R15]
        setFlags[FLAG_QUERY_ERROR] = cmdValid && txValid_q; // [R10]
        setFlags[FLAG_TRIGGER] = triggerSeen; // [R11]
        setFlags[FLAG_OP_COMPLETE] = opComplete; // [R11]
        // flags hold until cleared, a new event wins over the clear [R16]
        eventFlags_d = (clearFlags ? 8'h00 : eventFlags_q) | setFlags;
        summaryBit_d = |(eventFlags_d & eventEnable_d); // [R8]
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            eventEnable_q <= EVENT_ENABLE_RESET;
            eventFlags_q <= EVENT_FLAGS_RESET;
            summaryBit_q <= 1'b0;
            powerOnPending_q <= 1'b1;
            deviceClear_q <= 1'b0;
            busHalt_q <= 1'b0;
            unaddress_q <= 1'b0;
            serialPollOff_q <= 1'b0;
            controllerIsSystem_q <= 1'b0;
            errorQueueClear_q <= 1'b0;
            opcRequestClear_q <= 1'b0;
            outputQueueClear_q <= 1'b0;
        end
        else
        begin
            eventEnable_q <= eventEnable_d;
            eventFlags_q <= eventFlags_d;
            summaryBit_q <= summaryBit_d;
            powerOnPending_q <= powerOnPending_d;
            deviceClear_q <= deviceClear_d;
            busHalt_q <= busHalt_d;
            unaddress_q <= unaddress_d;
            serialPollOff_q <= serialPollOff_d;
            controllerIsSystem_q <= controllerIsSystem_d;
            errorQueueClear_q <= errorQueueClear_d;
            opcRequestClear_q <= opcRequestClear_d;
            outputQueueClear_q <= outputQueueClear_d;
        end
    end

    // response buffer and byte stream
    always_comb
    begin
        logic [31:0] txt;
        logic load;
        logic abort;
        txt = 32'h00000000;
        load = 1'b0;
        abort = deviceClear_d || (ifc && atn) || (cmdValid && txValid_q) // [R2] [R3] [R15]
            || (cmdValid && cmdCode == ISR_CMD_CLEAR_STATUS && afterTerminator); // [R5]
        respBuf_d = respBuf_q;
        respLen_d = respLen_q;
        respIdx_d = respIdx_q;
        txValid_d = txValid_q;
        txData_d = txData_q;
        if (txValid_q && txReady)
        begin
            if (respIdx_q == respLen_q)
                txValid_d = 1'b0;
            else
            begin
                txData_d = respBuf_q[respIdx_q];
                respIdx_d = respIdx_q + 5'h01;
            end
        end
        if (cmdValid && !txValid_q && !deviceClear_d && !(ifc && atn))
        begin
            unique case (cmdCode)
                ISR_CMD_ENABLE_QUERY:
                begin
                    txt = dec_text(eventEnable_q); // [R7]
                    respLen_d = dec_len(eventEnable_q);
                    load = 1'b1;
                end
                ISR_CMD_FLAGS_QUERY:
                begin
                    txt = dec_text(eventFlags_q); // [R12]
                    respLen_d = dec_len(eventFlags_q);
                    load = 1'b1;
                end
                ISR_CMD_IDENT_QUERY:
                begin
                    for (int i = 0; i < IDN_LEN; i++)
                        respBuf_d[i] = IDN_TEXT[8*(IDN_LEN-1-i) +: 8]; // [R14]
                    respLen_d = IDN_SEND_LEN;
                    load = 1'b1;
                end
                default:
                begin
                end
            endcase
            if (load && cmdCode != ISR_CMD_IDENT_QUERY)
            begin
                for (int i = 0; i < 4; i++)
                    respBuf_d[i] = txt[8*(3-i) +: 8];
            end
        end
        if (abort)
            txValid_d = 1'b0;
        else if (load)
        begin
            txValid_d = 1'b1;
            txData_d = respBuf_d[0];
            respIdx_d = 5'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < RESP_DEPTH; i++)
                respBuf_q[i] <= 8'h00;
            respLen_q <= 5'h00;
            respIdx_q <= 5'h00;
            txValid_q <= 1'b0;
            txData_q <= 8'h00;
            messageAvail_q <= 1'b0;
        end
        else
        begin
            respBuf_q <= respBuf_d;
            respLen_q <= respLen_d;
            respIdx_q <= respIdx_d;
            txValid_q <= txValid_d;
            txData_q <= txData_d;
            messageAvail_q <= txValid_d; // [R5]
        end
    end

endmodule

// ### isr_status_monitor.sv
// isr_status_monitor: port assertions for the status block.
// assumes it is bound to isr_status_reporting.
`timescale 1ns/1ns
module isr_status_monitor
    import ieee_status_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // command side
    input wire logic atn,
    input wire logic busCmdValid,
    input wire logic [7:0] busCmdCode,
    input wire logic ifc,
    input wire logic cmdValid,
    input wire ieee_status_pkg::isr_cmd_t cmdCode,
    input wire logic [7:0] cmdData,
    input wire logic afterTerminator,
    input wire logic keyPress,
    // design outputs
    input wire logic txValid_q,
    input wire logic [7:0] eventEnable_q,
    input wire logic [7:0] eventFlags_q,
    input wire logic summaryBit_q,
    input wire logic messageAvail_q,
    input wire logic deviceClear_q,
    input wire logic busHalt_q,
    input wire logic controllerIsSystem_q,
    input wire logic opcRequestClear_q,
    input wire logic outputQueueClear_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    sequence queryTaken;
        cmdValid && !txValid_q && cmdCode >= ISR_CMD_ENABLE_QUERY && !ifc && !busCmdValid;
    endsequence
    sequence flagsRead;
        queryTaken ##0 (cmdCode == ISR_CMD_FLAGS_QUERY && !keyPress);
    endsequence
    summary_bit_a: assert property (summaryBit_q == |(eventFlags_q & eventEnable_q))
        else $error("summary bit mismatch");
    enable_load_a: assert property (cmdValid && cmdCode == ISR_CMD_ENABLE_WRITE
        |=> eventEnable_q == $past(cmdData)) else $error("mask not loaded");
    flags_hold_a: assert property (!cmdValid
        |=> (eventFlags_q & $past(eventFlags_q)) == $past(eventFlags_q)) else $error("flag lost");
    key_flag_a: assert property (keyPress |=> eventFlags_q[FLAG_USER_REQUEST])
        else $error("key flag not set");
    bus_gate_a: assert property (busCmdValid && !atn |=> !deviceClear_q)
        else $error("clear taken without atn");
    dev_clear_a: assert property (busCmdValid && atn && busCmdCode == BUS_CODE_DEVICE_CLEAR
        |=> deviceClear_q && !txValid_q) else $error("device clear missing");
    ifc_act_a: assert property (ifc && atn |=> busHalt_q && controllerIsSystem_q)
        else $error("interface clear missing");
    clr_status_a: assert property (cmdValid && cmdCode == ISR_CMD_CLEAR_STATUS
        |=> opcRequestClear_q && outputQueueClear_q == $past(afterTerminator))
        else $error("clear status pulses wrong");
    answer_a: assert property (queryTaken |=> txValid_q && messageAvail_q)
        else $error("no response");
    flags_read_a: assert property (flagsRead |=> eventFlags_q[7:6] == 2'b00)
        else $error("flags not cleared by read");
endmodule
bind isr_status_reporting isr_status_monitor isr_status_monitor_inst (
    .clock(clock), .resetn(resetn), .atn(atn), .busCmdValid(busCmdValid),
    .busCmdCode(busCmdCode), .ifc(ifc), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .afterTerminator(afterTerminator), .keyPress(keyPress),
    .txValid_q(txValid_q), .eventEnable_q(eventEnable_q), .eventFlags_q(eventFlags_q),
    .summaryBit_q(summaryBit_q), .messageAvail_q(messageAvail_q),
    .deviceClear_q(deviceClear_q), .busHalt_q(busHalt_q),
    .controllerIsSystem_q(controllerIsSystem_q), .opcRequestClear_q(opcRequestClear_q),
    .outputQueueClear_q(outputQueueClear_q)
);

// ### isr_controller_model.sv
// isr_controller_model: bus controller side, takes response bytes.
// assumes stall comes from the bench.
`timescale 1ns/1ns
module isr_controller_model (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // response stream
    input wire logic txValid_q,
    input wire logic [7:0] txData_q,
    input wire logic stall,
    output logic txReady
);
    logic [7:0] rxBytes[$];
    int unsigned cnt = 0;
    always @(posedge clock)
    begin
        cnt <= cnt + 1;
        txReady <= resetn && !(stall && cnt[0]);
        if (txValid_q && txReady)
            rxBytes.push_back(txData_q);
    end
endmodule

// ### isr_status_reporting_tb.sv
// isr_status_reporting_tb: self-checking bench with a reference flag model.
// assumes the design, the monitor and the controller model.
`timescale 1ns/1ns
module isr_status_reporting_tb;
    import ieee_status_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, atn = 1'b0, busCmdValid = 1'b0;
    logic addressed = 1'b0, ifc = 1'b0, cmdValid = 1'b0, afterTerminator = 1'b0;
    logic stall = 1'b0;
    logic [7:0] busCmdCode = 8'h00, cmdData = 8'h00;
    isr_cmd_t cmdCode = ISR_CMD_CLEAR_STATUS;
    logic [5:0] ev = 6'h00;
    logic txValid_q, txReady, summaryBit_q, messageAvail_q, deviceClear_q, busHalt_q;
    logic unaddress_q, serialPollOff_q, controllerIsSystem_q, outputQueueClear_q;
    logic errorQueueClear_q, opcRequestClear_q;
    logic [7:0] txData_q, eventEnable_q, eventFlags_q;
    int num_errors = 0, n_checks = 0, refFlags = 0, refMask = 0, seed = 32'h1ef88d02;
    always #50 clock = ~clock;
    isr_status_reporting isr_status_reporting_inst (.clock(clock), .resetn(resetn),
        .atn(atn), .busCmdValid(busCmdValid), .busCmdCode(busCmdCode),
        .addressed(addressed), .ifc(ifc), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdData(cmdData), .afterTerminator(afterTerminator), .keyPress(ev[5]),
        .commandError(ev[4]), .executionError(ev[3]), .deviceError(ev[2]),
        .triggerSeen(ev[1]), .opComplete(ev[0]), .txValid_q(txValid_q),
        .txData_q(txData_q), .txReady(txReady), .eventEnable_q(eventEnable_q),
        .eventFlags_q(eventFlags_q), .summaryBit_q(summaryBit_q),
        .messageAvail_q(messageAvail_q), .deviceClear_q(deviceClear_q),
        .busHalt_q(busHalt_q), .unaddress_q(unaddress_q), .serialPollOff_q(serialPollOff_q),
        .controllerIsSystem_q(controllerIsSystem_q), .errorQueueClear_q(errorQueueClear_q),
        .opcRequestClear_q(opcRequestClear_q), .outputQueueClear_q(outputQueueClear_q));
    isr_controller_model isr_controller_model_inst (.clock(clock), .resetn(resetn),
        .txValid_q(txValid_q), .txData_q(txData_q), .stall(stall), .txReady(txReady));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cmd(isr_cmd_t c, logic [7:0] d, logic t);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdData <= d;
        afterTerminator <= t;
        @(posedge clock);
        cmdValid <= 1'b0;
        @(posedge clock);
    endtask
    task automatic query(isr_cmd_t c, string s);
        int i;
        isr_controller_model_inst.rxBytes.delete();
        cmd(c, 8'h00, 1'b0);
        for (i = 0; txValid_q !== 1'b0 && i < 200; i++)
            @(posedge clock);
        num_errors += (i == 200);
        if (i == 200)
            tally_and_finish();
        chk("length", s.len(), isr_controller_model_inst.rxBytes.size());
        foreach (isr_controller_model_inst.rxBytes[k])
            chk("byte", s[k], isr_controller_model_inst.rxBytes[k]);
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        refFlags = 128;
        chk("power on", refFlags, eventFlags_q);
        for (int n = 0; n < 4; n++)
        begin
            refMask = (n == 0) ? 255 : (n == 1) ? 0 : $random(seed) & 255;
            cmd(ISR_CMD_ENABLE_WRITE, refMask[7:0], 1'b0);
            chk("mask", refMask, eventEnable_q);
            chk("summary", |(refFlags & refMask), summaryBit_q);
            query(ISR_CMD_ENABLE_QUERY, $sformatf("%0d\n", refMask));
        end
        repeat (6)
        begin
            ev <= 6'($random(seed));
            stall <= 1'($random(seed));
            @(posedge clock);
            refFlags = refFlags | {ev[5:2], 1'b0, ev[1:0]};
        end
        ev <= 6'h00;
        repeat (3) @(posedge clock);
        chk("held", refFlags, eventFlags_q);
        chk("summary", |(refFlags & refMask), summaryBit_q);
        query(ISR_CMD_FLAGS_QUERY, $sformatf("%0d\n", refFlags));
        chk("read clear", 0, eventFlags_q);
        cmd(ISR_CMD_ENABLE_WRITE, 8'hc8, 1'b0);
        cmd(ISR_CMD_ENABLE_QUERY, 8'h00, 1'b0);
        cmd(ISR_CMD_ENABLE_WRITE, 8'h0f, 1'b0);
        chk("dropped", 0, txValid_q);
        chk("query error", 4, eventFlags_q);
        chk("mask", 15, eventEnable_q);
        for (int t = 0; t < 2; t++)
        begin
            cmd(ISR_CMD_CLEAR_STATUS, 8'h00, t[0]);
            chk("out clear", t, outputQueueClear_q);
            chk("err clear", 1, errorQueueClear_q);
            chk("opc clear", 1, opcRequestClear_q);
            chk("cleared", 0, eventFlags_q);
        end
        query(ISR_CMD_IDENT_QUERY, "ACME,PC100,0,1.0\n");
        for (int n = 0; n < 4; n++)
        begin
            atn <= n != 1;
            addressed <= n == 3;
            busCmdCode <= n < 2 ? BUS_CODE_DEVICE_CLEAR : BUS_CODE_SELECTED_CLEAR;
            busCmdValid <= 1'b1;
            @(posedge clock);
            busCmdValid <= 1'b0;
            @(posedge clock);
            chk("dev clear", n == 0 || n == 3, deviceClear_q);
        end
        ifc <= 1'b1;
        @(posedge clock);
        ifc <= 1'b0;
        @(posedge clock);
        chk("ifc", 8'h0f, {busHalt_q, unaddress_q, serialPollOff_q, controllerIsSystem_q});
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        chk("controller reset", 0, controllerIsSystem_q);
        chk("power on again", 128, eventFlags_q);
        tally_and_finish();
    end
endmodule
